// file: twcs_filter.sv
// Shared constants and the serial line synchroniser with deglitch filter
`timescale 1ns/100ps
`default_nettype none

package twcs_pkg;
   // System clock and deglitch delay (three 25 MHz crystal periods)
   localparam int CLK_PERIOD_NS = 10;
   localparam int DEGLITCH_NS = 120;
   localparam int DG_CYC_INT = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] DG_CYC = 4'(DG_CYC_INT);
   // Configuration register file
   localparam int REG_COUNT = 32;
   localparam logic [4:0] PTR_RESET = 5'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [4:0] REG_PWR_IDX = 5'h02;
   localparam int PWR_BIT = 5;
   localparam logic [4:0] REG_TRI_IDX = 5'h05;
   // Serial framing and power-down strap sampling delay
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] BOOT_CYC = 2'h2;
   // One-hot protocol states
   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_ADDR  = 9'h002,
      ST_AACK  = 9'h004,
      ST_REG   = 9'h008,
      ST_RACK  = 9'h010,
      ST_WDATA = 9'h020,
      ST_WACK  = 9'h040,
      ST_RDATA = 9'h080,
      ST_HACK  = 9'h100
   } twcs_state_e;
endpackage

module twcs_filter
   import twcs_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic pin,
   output logic level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic lvl;
      logic [3:0] cnt;
   } twcs_flt_s;

   twcs_flt_s q;
   twcs_flt_s n;

   // New level accepted only after it has held for the whole delay
   always_comb begin
      n = q;
      n.s1 = pin;
      n.s2 = q.s1;
      if (q.s2 == q.lvl) begin
         n.cnt = 4'h0;
      end else if (q.cnt == DG_CYC - 4'h1) begin
         n.lvl = q.s2; // see (RULE15)
         n.cnt = 4'h0;
      end else begin
         n.cnt = q.cnt + 4'h1;
      end
   end

   // Idle bus lines read high, so the filter resets high
   always_ff @(posedge clk) begin
      if (!rstn) begin
         q <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, cnt: 4'h0};
      end else begin
         q <= n;
      end
   end

   assign level = q.lvl;

   property p_deglitch;
      @(posedge clk) disable iff (!rstn)
         $changed(q.lvl) |-> $past(q.cnt) == DG_CYC - 4'h1;
   endproperty
   a_deglitch: assert property (p_deglitch) else $error("glitch passed"); // see (RULE15)
endmodule

`default_nettype wire

// file: twcs_slave.sv
// Two-wire configuration slave with register file and output disable
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// (RULE1) Host alone drives the serial clock; the device only samples it.
// (RULE2) Data line is open drain: pull low or release, never drive high.
// (RULE3) Device answers the 7-bit address set on seven pins.
// (RULE4) With no transfer in progress both lines are left released.
// (RULE5) Host starts each transfer by lowering data while clock is high.
// (RULE6) Device watches for a start and ignores everything before it.
// (RULE7) Host sends seven address bits then a direction bit, 1 reads.
// (RULE8) Device acknowledges only its own address, otherwise stays released.
// (RULE9) First written byte sets the register index for following transfers.
// (RULE10) Register pointer increments after every data byte transferred.
// (RULE11) Any number of data bytes may follow an acknowledged address.
// (RULE12) Stop is data rising while clock high; device then waits for start.
// (RULE13) Repeated start is taken as a fresh address phase.
// (RULE14) Transmit outputs go high impedance on power-down pin or bits.
// (RULE15) Serial clock is delayed and deglitched three crystal periods.
// (RULE16) Read data changes only after the filtered clock falling edge.
// (RULE17) Port works in power-down; power-down pin low at start enables it.
// (RULE18) Receiver acknowledges in ninth clock; host skips ack on last read.
module twcs_slave
   import twcs_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_N,
   input wire logic [6:0] SLAVE_ADDRESS_PINS,
   input wire logic POWER_DOWN_PIN,
   output logic [1:0] TX_HIGH_Z
);
   typedef struct packed {
      twcs_state_e st;
      logic [3:0] bcnt;
      logic [7:0] shf;
      logic [4:0] ptr;
      logic rw;
      logic drv;
      logic hack;
      logic scl_q;
      logic sda_q;
      logic [6:0] adr1;
      logic [6:0] adr2;
      logic pd1;
      logic pd2;
      logic [1:0] boot;
      logic init;
      logic [1:0] hiz;
      logic [REG_COUNT-1:0][7:0] cfg;
   } twcs_state_s;

   twcs_state_s q;
   twcs_state_s n;
   logic scl_f;
   logic sda_f;
   logic rise;
   logic fall;
   logic start;
   logic stop;

   // Pull low for a zero bit, release for a one
   function automatic logic pull_for(input logic [7:0] b);
      return !b[7];
   endfunction

   // Both lines get the same delay so start and stop keep their order
   twcs_filter u_scl (
      .clk(CLK),
      .rstn(RSTN),
      .pin(SCL),
      .level(scl_f)
   );
   twcs_filter u_sda (
      .clk(CLK),
      .rstn(RSTN),
      .pin(SDA_IN),
      .level(sda_f)
   );

   // Edge and bus condition detection on the filtered lines
   assign rise = scl_f && !q.scl_q;
   assign fall = !scl_f && q.scl_q;
   assign start = scl_f && q.scl_q && q.sda_q && !sda_f;
   assign stop = scl_f && q.scl_q && !q.sda_q && sda_f;

   // Protocol engine, register file and output disable
   always_comb begin
      n = q;
      n.scl_q = scl_f;
      n.sda_q = sda_f;
      n.adr1 = SLAVE_ADDRESS_PINS;
      n.adr2 = q.adr1;
      n.pd1 = POWER_DOWN_PIN;
      n.pd2 = q.pd1;
      // Strap sampled once synchronisers hold a settled value
      // Counter parks one past the check, so a late pin change cannot wake it
      if (q.boot != BOOT_CYC + 2'h1) begin
         n.boot = q.boot + 2'h1;
      end
      if (q.boot == BOOT_CYC) begin
         n.init = !q.pd2; // see (RULE17)
      end
      // Pin or register bits disable the transmit outputs
      n.hiz[0] = q.pd2 || q.cfg[REG_PWR_IDX][PWR_BIT] || q.cfg[REG_TRI_IDX][0]; // see (RULE14)
      n.hiz[1] = q.pd2 || q.cfg[REG_PWR_IDX][PWR_BIT] || q.cfg[REG_TRI_IDX][1]; // see (RULE14)
      if (!q.init) begin
         n.st = ST_IDLE;
         n.drv = 1'b0;
      end else if (start) begin
         n.st = ST_ADDR; // see (RULE6) (RULE13)
         n.bcnt = 4'h0;
         n.drv = 1'b0;
      end else if (stop) begin
         n.st = ST_IDLE; // see (RULE4)
         n.drv = 1'b0;
      end else begin
         case (q.st)
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (rise) begin
                  n.shf = {q.shf[6:0], sda_f};
                  n.bcnt = q.bcnt + 4'h1;
               end else if (fall && q.bcnt == BITS_PER_BYTE) begin
                  n.drv = 1'b1; // see (RULE18)
                  if (q.st == ST_ADDR) begin
                     if (q.shf[7:1] == q.adr2) begin
                        n.rw = q.shf[0]; // see (RULE3) (RULE8)
                        n.st = ST_AACK;
                     end else begin
                        n.drv = 1'b0;
                        n.st = ST_IDLE;
                     end
                  end else if (q.st == ST_REG) begin
                     n.ptr = q.shf[4:0];
                     n.st = ST_RACK;
                  end else begin
                     n.cfg[q.ptr] = q.shf;
                     n.ptr = q.ptr + 5'h01; // see (RULE10)
                     n.st = ST_WACK;
                  end
               end
            end
            ST_AACK: begin
               if (fall) begin
                  n.bcnt = 4'h0;
                  if (q.rw) begin
                     n.shf = q.cfg[q.ptr];
                     n.drv = pull_for(q.cfg[q.ptr]); // see (RULE16)
                     n.st = ST_RDATA;
                  end else begin
                     n.drv = 1'b0;
                     n.st = ST_REG;
                  end
               end
            end
            ST_RACK, ST_WACK: begin
               if (fall) begin
                  n.drv = 1'b0;
                  n.bcnt = 4'h0;
                  n.st = ST_WDATA; // see (RULE11)
               end
            end
            ST_RDATA: begin
               if (rise) begin
                  n.bcnt = q.bcnt + 4'h1;
               end else if (fall) begin
                  if (q.bcnt == BITS_PER_BYTE) begin
                     n.drv = 1'b0;
                     n.ptr = q.ptr + 5'h01; // see (RULE10)
                     n.st = ST_HACK;
                  end else begin
                     n.shf = {q.shf[6:0], 1'b0};
                     n.drv = pull_for({q.shf[6:0], 1'b0}); // see (RULE16)
                  end
               end
            end
            ST_HACK: begin
               if (rise) begin
                  n.hack = !sda_f;
               end else if (fall) begin
                  if (q.hack) begin
                     n.shf = q.cfg[q.ptr];
                     n.drv = pull_for(q.cfg[q.ptr]);
                     n.bcnt = 4'h0;
                     n.st = ST_RDATA; // see (RULE11)
                  end else begin
                     n.st = ST_IDLE; // see (RULE18)
                  end
               end
            end
            ST_IDLE: begin
               n.drv = 1'b0;
            end
            default: begin
               n.st = ST_IDLE;
               n.drv = 1'b0;
            end
         endcase
      end
   end

   // Registered state; configuration returns to defaults on reset
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.ptr <= PTR_RESET;
         q.scl_q <= 1'b1;
         q.sda_q <= 1'b1;
         q.cfg <= {REG_COUNT{CFG_RESET}};
      end else begin
         q <= n;
      end
   end

   // Only pull low, never drive a high level
   assign SDA_OUT = 1'b0; // see (RULE2)
   assign SDA_OE_N = !q.drv;
   assign TX_HIGH_Z = q.hiz;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   property p_pull_states;
      !SDA_OE_N |-> q.st inside {ST_AACK, ST_RACK, ST_WACK, ST_RDATA};
   endproperty
   a_pull_states: assert property (p_pull_states) else $error("pull outside slot"); // see (RULE2)
   property p_idle_free;
      q.st == ST_IDLE |-> SDA_OE_N;
   endproperty
   a_idle_free: assert property (p_idle_free) else $error("idle bus pulled"); // see (RULE4)
   property p_own_addr;
      $rose(q.st == ST_AACK) |-> $past(q.shf[7:1]) == q.adr2 && !SDA_OE_N;
   endproperty
   a_own_addr: assert property (p_own_addr) else $error("bad address ack"); // see (RULE8)
   property p_start;
      q.init && start |=> q.st == ST_ADDR && q.bcnt == 4'h0;
   endproperty
   a_start: assert property (p_start) else $error("start not taken"); // see (RULE13)
   property p_after_fall;
      $fell(SDA_OE_N) |-> $past(fall, 1);
   endproperty
   a_after_fall: assert property (p_after_fall) else $error("pull not on fall"); // see (RULE16)
   property p_wr_inc;
      $rose(q.st == ST_WACK) |-> q.ptr == 5'($past(q.ptr) + 5'h01);
   endproperty
   a_wr_inc: assert property (p_wr_inc) else $error("pointer stuck"); // see (RULE10)
   property p_hiz;
      ##1 TX_HIGH_Z[0] == $past(q.pd2 || q.cfg[REG_PWR_IDX][PWR_BIT] || q.cfg[REG_TRI_IDX][0]);
   endproperty
   a_hiz: assert property (p_hiz) else $error("output disable wrong"); // see (RULE14)
   property p_no_init;
      !q.init |-> SDA_OE_N && q.st == ST_IDLE;
   endproperty
   a_no_init: assert property (p_no_init) else $error("port active uninit"); // see (RULE17)
   property p_boot_once;
      q.boot == BOOT_CYC + 2'h1 |=> $stable(q.init);
   endproperty
   a_boot_once: assert property (p_boot_once) else $error("strap read twice"); // see (RULE17)
   property p_nack_end;
      q.init && q.st == ST_HACK && fall && !q.hack && !start && !stop |=> q.st == ST_IDLE;
   endproperty
   a_nack_end: assert property (p_nack_end) else $error("read after nack"); // see (RULE18)

   c_write: cover property (q.st == ST_WACK);
   c_read: cover property (q.st == ST_HACK && fall && q.hack);
   c_restart: cover property (start && q.st == ST_WDATA);
endmodule

`default_nettype wire

// file: twcs_host.sv
// Host-side bus master model driving the serial clock and data lines
`timescale 1ns/100ps
`default_nettype none

module twcs_host
   import twcs_pkg::*;
#(
   parameter int Q = 160
)
(
   input wire logic sda,
   output var logic scl,
   output var logic sda_pull
);
   // Idle bus: clock high, data left to the pull-up
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // Works from idle and, with the clock low, as a repeated start
   task automatic start();
      #Q sda_pull = 1'b0;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b1;
      #Q scl = 1'b0;
   endtask

   // Data rises with the clock high, then the bus rests released
   task automatic stop();
      #Q sda_pull = 1'b1;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b0;
      #(4*Q);
   endtask

   // Data moves only while the clock is low, so no false start or stop
   task automatic bit_io(input logic b, output logic r);
      #Q sda_pull = !b;
      #Q scl = 1'b1;
      #(2*Q) r = sda;
      scl = 1'b0;
   endtask

   // Address, index or data byte, MSB first, then the ninth clock
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask

   // Host withholds its acknowledge on the last byte it wants
   task automatic get(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(!more, r);
   endtask

   // Clock pulse far shorter than the deglitch window
   task automatic glitch();
      #(2*Q) scl = 1'b1;
      #50 scl = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: twcs_slave_test.sv
// Self-checking bench for the two-wire configuration slave
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      n_fail++; \
      $display("unexpected at %0t got %h exp %h", $time, got, exp); \
   end \
end

module twcs_slave_test
   import twcs_pkg::*;
;
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic POWER_DOWN_PIN = 1'b0;
   logic [6:0] SLAVE_ADDRESS_PINS = 7'h2D;
   logic scl, sda_pull, sda_out, sda_oe_n, sda, ack;
   logic [1:0] tx_high_z;
   logic [7:0] rd;
   int n_fail = 0;
   int comparisons = 0;

   always #5 CLK = ~CLK;
   // Open-drain wire with pull-up: anyone pulling wins
   assign sda = (sda_pull || !sda_oe_n) ? 1'b0 : 1'b1;

   twcs_slave twcs_slave_i (.CLK(CLK), .RSTN(RSTN), .SCL(scl),
      .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
      .SLAVE_ADDRESS_PINS(SLAVE_ADDRESS_PINS),
      .POWER_DOWN_PIN(POWER_DOWN_PIN), .TX_HIGH_Z(tx_high_z));
   twcs_host twcs_host_i (.sda(sda), .scl(scl), .sda_pull(sda_pull));

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Power-down strap held past the boot check, then lowered
   task automatic do_reset(input logic pd);
      if (RSTN) begin
         @(posedge CLK);
         #1 RSTN = 1'b0;
      end
      POWER_DOWN_PIN = pd;
      repeat (2) @(posedge CLK);
      #1 RSTN = 1'b1;
      repeat (12) @(posedge CLK);
      #1 POWER_DOWN_PIN = 1'b0;
   endtask

   task automatic sel(input logic rw, input logic exp_ack);
      twcs_host_i.start();
      twcs_host_i.put({SLAVE_ADDRESS_PINS, rw}, ack);
      `CHK(ack, exp_ack)
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d [$]);
      sel(1'b0, 1'b1);
      twcs_host_i.put(idx, ack);
      `CHK(ack, 1'b1)
      foreach (d[i]) begin
         twcs_host_i.put(d[i], ack);
         `CHK(ack, 1'b1)
      end
      twcs_host_i.stop();
   endtask

   task automatic rd_regs(input logic [7:0] idx, input logic [7:0] e [$]);
      sel(1'b0, 1'b1);
      twcs_host_i.put(idx, ack);
      `CHK(ack, 1'b1)
      sel(1'b1, 1'b1);
      foreach (e[i]) begin
         twcs_host_i.get(i < e.size() - 1, rd);
         `CHK(rd, e[i])
      end
      // Clock held low past the filtered fall: a nacked slave must let go
      repeat (20) @(posedge CLK);
      #1 `CHK(sda_oe_n, 1'b1)
      twcs_host_i.stop();
   endtask

   // Bytes with no start before them must be ignored
   task automatic t_idle();
      `CHK(sda_oe_n, 1'b1)
      `CHK(sda_out, 1'b0)
      `CHK(tx_high_z, 2'b00)
      // Released clocks first lower the clock without a start condition
      twcs_host_i.get(1'b1, rd);
      `CHK(rd, 8'hFF)
      twcs_host_i.put({SLAVE_ADDRESS_PINS, 1'b0}, ack);
      `CHK(ack, 1'b0)
      twcs_host_i.stop();
   endtask

   task automatic t_wrong();
      for (int i = 0; i < 7; i++) begin
         twcs_host_i.start();
         twcs_host_i.put({SLAVE_ADDRESS_PINS ^ 7'(1 << i), 1'b0}, ack);
         `CHK(ack, 1'b0)
         twcs_host_i.stop();
      end
   endtask

   // A counted glitch would shift every later bit by one
   task automatic t_glitch();
      sel(1'b0, 1'b1);
      twcs_host_i.glitch();
      twcs_host_i.put(8'h10, ack);
      `CHK(ack, 1'b1)
      twcs_host_i.put(8'h77, ack);
      `CHK(ack, 1'b1)
      twcs_host_i.stop();
      rd_regs(8'h10, '{8'h77});
   endtask

   // Pointer wraps from the last register; index top bits unused
   task automatic t_wrap();
      wr(8'h1E, '{8'hA5, 8'h3C, 8'h5A});
      rd_regs(8'hFE, '{8'hA5, 8'h3C, 8'h5A});
      rd_regs(8'h1F, '{8'h3C, 8'h5A});
   endtask

   task automatic t_power();
      logic [7:0] idx [5] = '{8'h05, 8'h05, 8'h05, 8'h02, 8'h02};
      logic [7:0] val [5] = '{8'h01, 8'h02, 8'h00, 8'h20, 8'h00};
      logic [7:0] tri_v = 8'h00;
      logic [7:0] pwr_v = 8'h00;
      for (int i = 0; i < 5; i++) begin
         if (i == 4) POWER_DOWN_PIN = 1'b1;
         wr(idx[i], '{val[i]});
         if (idx[i][4:0] == REG_TRI_IDX) tri_v = val[i];
         else pwr_v = val[i];
         repeat (5) @(posedge CLK);
         #1 `CHK(tx_high_z, tri_v[1:0] | {2{POWER_DOWN_PIN | pwr_v[PWR_BIT]}})
         rd_regs(idx[i], '{val[i]});
      end
      POWER_DOWN_PIN = 1'b0;
      repeat (5) @(posedge CLK);
      #1 `CHK(tx_high_z, 2'b00)
   endtask

   // Strap high at boot leaves the port dead until the next reset
   task automatic t_boot();
      do_reset(1'b1);
      sel(1'b0, 1'b0);
      twcs_host_i.stop();
      do_reset(1'b0);
      sel(1'b0, 1'b1);
      twcs_host_i.stop();
   endtask

   initial begin
      do_reset(1'b0);
      t_idle();
      t_wrong();
      t_glitch();
      t_wrap();
      t_power();
      t_boot();
      finish_test();
   end

   // Hang guard
   initial begin
      repeat (100000) @(posedge CLK);
      n_fail++;
      finish_test();
   end
endmodule
`default_nettype wire
